// ---- core/jpu_core.sv ----
// How it works
// - unlock only via mailbox password check
// - window timeout forces brownout reset
// - wrong password forces brownout reset
// - after release, device enters deep sleep if a sleep request word was sent
// - eight-bit instruction, first bit lands LSB
// - identification value out during instruction shift
// - sixteen-bit data MSB first, old out
// - control register commands power-up clear
// - reset marker starts at reset vector
// - brownout also resets the test port
`timescale 1ns/10ps
`default_nettype none
module jpu_core #(
    parameter int unsigned WINDOW_CYC = jpu_pkg::WINDOW_CYC,  // exchange window in cycles
    parameter int unsigned PW_WORDS   = 4                     // password length in words
) (
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_b_in,
    input  wire logic                   tck_in,
    input  wire logic                   tms_in,
    input  wire logic                   tdi_in,
    input  wire logic [16*PW_WORDS-1:0] password_in,
    input  wire logic [15:0]            reset_vector_in,
    output logic                        tdo_out,
    output logic                        tdo_oe_b_out,
    output logic                        cpu_hold_out,
    output logic                        wdt_hold_out,
    output logic                        por_out,
    output logic                        brownout_reset_out,
    output logic                        unlock_out,
    output logic                        deep_sleep_out,
    output logic                        window_out,
    output logic                        start_out,
    output logic [15:0]                 start_addr_out
);
    localparam int TW = $clog2(WINDOW_CYC + 1);
    localparam int IW = (PW_WORDS > 1) ? $clog2(PW_WORDS) : 1;

    // next port state from tms
    function automatic jpu_pkg::jpu_tap_t tap_next(input jpu_pkg::jpu_tap_t s,
                                                   input logic tms);
        case (s)
            jpu_pkg::TAP_RESET:  tap_next = tms ? jpu_pkg::TAP_RESET  : jpu_pkg::TAP_IDLE;
            jpu_pkg::TAP_IDLE:   tap_next = tms ? jpu_pkg::TAP_SEL_DR : jpu_pkg::TAP_IDLE;
            jpu_pkg::TAP_SEL_DR: tap_next = tms ? jpu_pkg::TAP_SEL_IR : jpu_pkg::TAP_CAP_DR;
            jpu_pkg::TAP_CAP_DR: tap_next = tms ? jpu_pkg::TAP_EX1_DR : jpu_pkg::TAP_SH_DR;
            jpu_pkg::TAP_SH_DR:  tap_next = tms ? jpu_pkg::TAP_EX1_DR : jpu_pkg::TAP_SH_DR;
            jpu_pkg::TAP_EX1_DR: tap_next = tms ? jpu_pkg::TAP_UPD_DR : jpu_pkg::TAP_PAU_DR;
            jpu_pkg::TAP_PAU_DR: tap_next = tms ? jpu_pkg::TAP_EX2_DR : jpu_pkg::TAP_PAU_DR;
            jpu_pkg::TAP_EX2_DR: tap_next = tms ? jpu_pkg::TAP_UPD_DR : jpu_pkg::TAP_SH_DR;
            jpu_pkg::TAP_SEL_IR: tap_next = tms ? jpu_pkg::TAP_RESET  : jpu_pkg::TAP_CAP_IR;
            jpu_pkg::TAP_CAP_IR: tap_next = tms ? jpu_pkg::TAP_EX1_IR : jpu_pkg::TAP_SH_IR;
            jpu_pkg::TAP_SH_IR:  tap_next = tms ? jpu_pkg::TAP_EX1_IR : jpu_pkg::TAP_SH_IR;
            jpu_pkg::TAP_EX1_IR: tap_next = tms ? jpu_pkg::TAP_UPD_IR : jpu_pkg::TAP_PAU_IR;
            jpu_pkg::TAP_PAU_IR: tap_next = tms ? jpu_pkg::TAP_EX2_IR : jpu_pkg::TAP_PAU_IR;
            jpu_pkg::TAP_EX2_IR: tap_next = tms ? jpu_pkg::TAP_UPD_IR : jpu_pkg::TAP_SH_IR;
            default:             tap_next = tms ? jpu_pkg::TAP_SEL_DR : jpu_pkg::TAP_IDLE;
        endcase
    endfunction

    logic                  tck_rise;      // synced clock rising edge
    logic                  tck_fall;      // synced clock falling edge
    logic                  tms_s;         // synced mode select
    logic                  tdi_s;         // synced data in
    jpu_pkg::jpu_tap_t     tap_ff;        // port state
    jpu_pkg::jpu_mbmode_t  mb_ff;         // mailbox word mode
    logic [7:0]            instr_ff;      // current instruction
    logic [7:0]            ir_sh_ff;      // instruction shifter
    logic [15:0]           dr_sh_ff;      // data shifter
    logic [15:0]           ctl_ff;        // control-signal register
    logic                  sleep_req_ff;  // deep sleep asked for
    logic                  xchg_ff;       // exchange request pending
    logic [TW-1:0]         tmr_ff;        // window countdown
    logic [IW-1:0]         pw_idx_ff;     // password word index
    logic                  pw_bad_ff;     // some word already missed

    // pin synchroniser and clock edge finder
    jpu_pin_sync u_sync (
        .clk_sys_in   (clk_sys_in),
        .rst_b_in     (rst_b_in),
        .tck_in       (tck_in),
        .tms_in       (tms_in),
        .tdi_in       (tdi_in),
        .tck_rise_out (tck_rise),
        .tck_fall_out (tck_fall),
        .tms_out      (tms_s),
        .tdi_out      (tdi_s)
    );

    // port events, each one cycle wide on a clock rise, and the in_reset state level
    wire cap_ir   = tck_rise && tap_ff == jpu_pkg::TAP_CAP_IR;
    wire sh_ir    = tck_rise && tap_ff == jpu_pkg::TAP_SH_IR;
    wire upd_ir   = tck_rise && tap_ff == jpu_pkg::TAP_UPD_IR;
    wire cap_dr   = tck_rise && tap_ff == jpu_pkg::TAP_CAP_DR;
    wire sh_dr    = tck_rise && tap_ff == jpu_pkg::TAP_SH_DR;
    wire upd_dr   = tck_rise && tap_ff == jpu_pkg::TAP_UPD_DR;
    wire in_reset = tap_ff == jpu_pkg::TAP_RESET;
    // register selection by instruction
    wire sel_mb   = instr_ff == jpu_pkg::INSTR_MAILBOX;
    wire sel_ctl  = instr_ff == jpu_pkg::INSTR_CTRL;
    wire sel_rel  = instr_ff == jpu_pkg::INSTR_RELEASE;
    wire sel_wide = sel_mb || sel_ctl || sel_rel;
    wire wr_mb    = upd_dr && sel_mb;
    wire wr_ctl   = upd_dr && sel_ctl;
    wire wr_rel   = upd_dr && sel_rel;
    // release: hold bit dropped or release instruction updated
    wire rel_evt  = wr_rel || (wr_ctl && ctl_ff[jpu_pkg::CTL_HOLD_BIT]
                               && !dr_sh_ff[jpu_pkg::CTL_HOLD_BIT]);
    // password compare while the window is open
    wire pw_wr    = wr_mb && mb_ff == jpu_pkg::MB_NARROW && window_out;
    wire pw_hit   = dr_sh_ff == password_in[16*pw_idx_ff +: 16];
    wire pw_last  = pw_idx_ff == IW'(PW_WORDS - 1);
    wire pw_ok    = pw_wr && pw_last && pw_hit && !pw_bad_ff;
    wire pw_fail  = pw_wr && pw_last && !(pw_hit && !pw_bad_ff);
    wire timeout  = window_out && tmr_ff == TW'(1);
    wire brown_req = timeout || pw_fail;
    // capture value of the selected data register
    wire [15:0] status = {12'h000, xchg_ff, deep_sleep_out, unlock_out, window_out};
    wire [15:0] dr_cap = sel_mb  ? status :
                         sel_ctl ? ctl_ff :
                         sel_rel ? start_addr_out : 16'h0000;
    wire        dr_bit = sel_wide ? dr_sh_ff[15] : dr_sh_ff[0];
    wire        shifting = tap_ff == jpu_pkg::TAP_SH_IR || tap_ff == jpu_pkg::TAP_SH_DR;
    wire jpu_pkg::jpu_tap_t nxt_tap = tck_rise ? tap_next(tap_ff, tms_s) : tap_ff;

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tap_ff   <= jpu_pkg::TAP_RESET;
            instr_ff <= jpu_pkg::INSTR_BYPASS;
        end else if (brown_req) begin
            tap_ff   <= jpu_pkg::TAP_RESET;
            instr_ff <= jpu_pkg::INSTR_BYPASS;
        end else begin
            tap_ff   <= nxt_tap;
            instr_ff <= in_reset ? jpu_pkg::INSTR_BYPASS : (upd_ir ? ir_sh_ff : instr_ff);
        end
    end

    // shifters; IR shifts right so the first bit lands in bit 0
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ir_sh_ff <= 8'h00;
            dr_sh_ff <= 16'h0000;
        end else begin
            if (cap_ir) ir_sh_ff <= jpu_pkg::PORT_ID;
            else if (sh_ir) ir_sh_ff <= {tdi_s, ir_sh_ff[7:1]};
            if (cap_dr) dr_sh_ff <= dr_cap;
            else if (sh_dr) dr_sh_ff <= {dr_sh_ff[14:0], tdi_s};
        end
    end

    // data out changes on the falling clock; driven only while shifting
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tdo_out      <= 1'b0;
            tdo_oe_b_out <= 1'b1;
        end else if (tck_fall) begin
            tdo_out      <= (tap_ff == jpu_pkg::TAP_SH_IR) ? ir_sh_ff[0] : dr_bit;
            tdo_oe_b_out <= !shifting;
        end
    end

    // mailbox mode and request words; port reset drops the mode only
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mb_ff        <= jpu_pkg::MB_IDLE;
            sleep_req_ff <= 1'b0;
            xchg_ff      <= 1'b0;
        end else if (brown_req || rel_evt) begin
            mb_ff        <= jpu_pkg::MB_IDLE;
            sleep_req_ff <= 1'b0;
            xchg_ff      <= 1'b0;
        end else begin
            if (in_reset || upd_ir) mb_ff <= jpu_pkg::MB_IDLE;
            else if (wr_mb && mb_ff == jpu_pkg::MB_IDLE) begin
                if (dr_sh_ff == jpu_pkg::MB_MODE32) mb_ff <= jpu_pkg::MB_WIDE;
                else if (dr_sh_ff == jpu_pkg::MB_MODE16) mb_ff <= jpu_pkg::MB_NARROW;
            end
            if (wr_mb && mb_ff == jpu_pkg::MB_WIDE) begin
                if (dr_sh_ff == jpu_pkg::MB_SLEEP_REQ) sleep_req_ff <= 1'b1;
                if (dr_sh_ff == jpu_pkg::MB_XCHG_REQ) xchg_ff <= 1'b1;
            end
        end
    end

    // control register; power-up clear is a one-cycle pulse
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl_ff <= jpu_pkg::CTL_RESET;
            por_out <= 1'b0;
        end else begin
            if (brown_req) ctl_ff <= jpu_pkg::CTL_RESET;
            else if (wr_ctl) ctl_ff <= dr_sh_ff;
            else if (wr_rel) ctl_ff[jpu_pkg::CTL_HOLD_BIT] <= 1'b0;
            por_out <= wr_ctl && dr_sh_ff[jpu_pkg::CTL_POR_BIT] && !brown_req;
        end
    end
    assign cpu_hold_out = ctl_ff[jpu_pkg::CTL_HOLD_BIT];
    assign wdt_hold_out = ctl_ff[jpu_pkg::CTL_WDT_BIT];

    // release and start address
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            start_out      <= 1'b0;
            start_addr_out <= 16'h0000;
        end else begin
            start_out <= wr_rel;
            if (wr_rel) begin
                start_addr_out <= (dr_sh_ff == jpu_pkg::RESET_MARK) ? reset_vector_in
                                                                    : dr_sh_ff;
            end
        end
    end

    // exchange window, opened by the release after a request
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            window_out <= 1'b0;
            tmr_ff     <= '0;
            pw_idx_ff  <= '0;
            pw_bad_ff  <= 1'b0;
        end else if (brown_req || pw_ok) begin
            window_out <= 1'b0;
            tmr_ff     <= '0;
        end else if (rel_evt && xchg_ff) begin
            window_out <= 1'b1;
            tmr_ff     <= TW'(WINDOW_CYC);
            pw_idx_ff  <= '0;
            pw_bad_ff  <= 1'b0;
        end else if (window_out) begin
            tmr_ff <= tmr_ff - TW'(1);
            if (pw_wr) begin
                pw_idx_ff <= pw_idx_ff + IW'(1);
                pw_bad_ff <= pw_bad_ff | !pw_hit;
            end
        end
    end

    // outcome: unlock, brownout pulse, deep sleep
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            unlock_out         <= 1'b0;
            brownout_reset_out <= 1'b0;
            deep_sleep_out     <= 1'b0;
        end else begin
            brownout_reset_out <= brown_req;
            unlock_out <= !brown_req && (unlock_out || pw_ok);
            deep_sleep_out <= !brown_req && (rel_evt ? sleep_req_ff : deep_sleep_out);
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_pw_bad;
        pw_wr && pw_last && (!pw_hit || pw_bad_ff);
    endsequence
    sequence s_rel_mark;
        wr_rel && dr_sh_ff == jpu_pkg::RESET_MARK;
    endsequence

    AST_TIMEOUT_BROWN: assert property (timeout |=> brownout_reset_out && !window_out)
        else $error("timeout did not raise brownout");
    AST_BAD_PW_BROWN: assert property (s_pw_bad |=> brownout_reset_out ##1 !unlock_out)
        else $error("wrong password did not raise brownout");
    AST_UNLOCK_CAUSE: assert property ($rose(unlock_out) |-> $past(pw_wr && pw_hit))
        else $error("unlock without matching password");
    AST_BOR_PORT: assert property (brownout_reset_out |-> in_reset && !cpu_hold_out)
        else $error("brownout left port active");
    AST_ID_LOAD: assert property (cap_ir |=> ir_sh_ff == jpu_pkg::PORT_ID)
        else $error("identification value not captured");
    AST_IR_LSB: assert property (sh_ir |=> ir_sh_ff[7] == $past(tdi_s))
        else $error("instruction bit order wrong");
    AST_DR_MSB: assert property (tck_fall && tap_ff == jpu_pkg::TAP_SH_DR && sel_wide
                                 |=> tdo_out == $past(dr_sh_ff[15]) && !tdo_oe_b_out)
        else $error("data output bit wrong");
    AST_POR_PULSE: assert property (wr_ctl && dr_sh_ff[jpu_pkg::CTL_POR_BIT] && !brown_req
                                    |=> por_out ##1 !por_out)
        else $error("power-up clear pulse wrong");
    AST_VECTOR: assert property (s_rel_mark |=> start_out
                                 && start_addr_out == $past(reset_vector_in))
        else $error("reset marker did not start at vector");
    AST_SLEEP: assert property (rel_evt && sleep_req_ff && !brown_req |=> deep_sleep_out)
        else $error("deep sleep not entered after release");
endmodule
`default_nettype wire

// ---- core/jpu_pkg.sv ----
`default_nettype none
package jpu_pkg;
    // instruction and data register widths
    localparam int          IR_W          = 8;
    localparam int          DR_W          = 16;
    // instruction codes
    localparam logic [7:0]  INSTR_MAILBOX = 8'h61;  // mailbox exchange instruction
    localparam logic [7:0]  INSTR_CTRL    = 8'h13;  // control-signal register
    localparam logic [7:0]  INSTR_RELEASE = 8'h14;  // release with start address
    localparam logic [7:0]  INSTR_BYPASS  = 8'hFF;  // one-bit bypass
    // port identification value, arbitrary
    localparam logic [7:0]  PORT_ID       = 8'h5A;
    // mailbox words and the release reset marker
    localparam logic [15:0] MB_MODE32     = 16'h0011;
    localparam logic [15:0] MB_MODE16     = 16'h0001;
    localparam logic [15:0] MB_SLEEP_REQ  = 16'hA55A;
    localparam logic [15:0] MB_XCHG_REQ   = 16'h1E1E;
    localparam logic [15:0] RESET_MARK    = 16'hFFFE;
    // control-signal register fields
    localparam int          CTL_HOLD_BIT  = 0;
    localparam int          CTL_POR_BIT   = 1;
    localparam int          CTL_WDT_BIT   = 2;
    localparam logic [15:0] CTL_RESET     = 16'h0000;
    // mailbox status word fields
    localparam int          ST_WINDOW_BIT = 0;
    localparam int          ST_UNLOCK_BIT = 1;
    localparam int          ST_SLEEP_BIT  = 2;
    localparam int          ST_XCHG_BIT   = 3;
    // password exchange window
    localparam int          WINDOW_MS     = 1200;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          WINDOW_CYC    = WINDOW_MS * (CLK_HZ / 1000);
    // test access port states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
        TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } jpu_tap_t;
    // mailbox word width mode
    typedef enum logic [1:0] {MB_IDLE, MB_WIDE, MB_NARROW} jpu_mbmode_t;
endpackage
`default_nettype wire

// ---- core/jpu_pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module jpu_pin_sync (
    input  wire logic clk_sys_in,
    input  wire logic rst_b_in,
    input  wire logic tck_in,
    input  wire logic tms_in,
    input  wire logic tdi_in,
    output logic      tck_rise_out,
    output logic      tck_fall_out,
    output logic      tms_out,
    output logic      tdi_out
);
    logic [2:0] meta_ff;   // first stage, read only by the second
    logic [2:0] sync_ff;   // second stage: {tck, tms, tdi}
    logic       tck_d_ff;  // previous synced clock level

    // two-flop synchroniser, then one more flop for edge finding
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_ff  <= 3'h0;
            sync_ff  <= 3'h0;
            tck_d_ff <= 1'b0;
        end else begin
            meta_ff  <= {tck_in, tms_in, tdi_in};
            sync_ff  <= meta_ff;
            tck_d_ff <= sync_ff[2];
        end
    end

    // tms and tdi share the clock's delay, so they align with its edges
    assign tck_rise_out = sync_ff[2] & ~tck_d_ff;
    assign tck_fall_out = ~sync_ff[2] & tck_d_ff;
    assign tms_out      = sync_ff[1];
    assign tdi_out      = sync_ff[0];
endmodule
`default_nettype wire

// ---- verif/jpu_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module jpu_host_model (
    input  wire logic tdo_in,
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out
);
    // link clock stands low between frames
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // one link cycle; tdo read late in the high phase, after its fall update settled
    task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
        tms_out = tms_v;
        tdi_out = tdi_v;
        #400 tck_out = 1'b1;
        #390 tdo_v = tdo_in;
        #10 tck_out = 1'b0;
    endtask
    // walk n states, tms taken lsb first from seq
    task automatic walk(input logic [3:0] seq, input int n);
        logic d;
        for (int i = 0; i < n; i++) step(seq[i], tdi_out, d);
    endtask
    task automatic tap_reset();
        walk(4'hF, 4);
        walk(4'h1, 2);
    endtask
    // host byte goes lsb first, so code bit 0 lands in bit 0
    task automatic ir_shift(input logic [7:0] code, output logic [7:0] cap);
        walk(4'h3, 4);
        for (int i = 0; i < 8; i++) step(i == 7, code[i], cap[i]);
        walk(4'h1, 2);
        // released data line must not show the last bit
        tdi_out = ~tdi_out;
    endtask
    // data msb first, old word comes back
    task automatic dr_shift(input logic [15:0] data, output logic [15:0] old);
        logic d;
        walk(4'h1, 3);
        for (int i = 0; i < 16; i++) begin
            step(i == 15, data[15 - i], d);
            old[15 - i] = d;
        end
        walk(4'h1, 2);
        tdi_out = ~tdi_out;
    endtask
    // first phase: hold, request words, release
    task automatic request_exchange();
        logic [15:0] d;
        logic [7:0]  c;
        tap_reset();
        ir_shift(jpu_pkg::INSTR_CTRL, c);
        dr_shift(16'h0001, d);
        ir_shift(jpu_pkg::INSTR_MAILBOX, c);
        dr_shift(jpu_pkg::MB_MODE32, d);
        dr_shift(jpu_pkg::MB_SLEEP_REQ, d);
        dr_shift(jpu_pkg::MB_XCHG_REQ, d);
        ir_shift(jpu_pkg::INSTR_CTRL, c);
        dr_shift(16'h0000, d);
    endtask
    // second phase, sent promptly inside the window
    task automatic send_password(input logic [63:0] pw, input int n);
        logic [15:0] d;
        logic [7:0]  c;
        tap_reset();
        ir_shift(jpu_pkg::INSTR_MAILBOX, c);
        dr_shift(jpu_pkg::MB_MODE16, d);
        for (int i = 0; i < n; i++) dr_shift(pw[16*i +: 16], d);
    endtask
endmodule
`default_nettype wire

// ---- verif/jtag_password_unlock_access_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module jtag_password_unlock_access_tb_top;
    localparam int unsigned WIN = 3000;                  // shortened exchange window
    localparam logic [63:0] PW  = 64'hC0DE_4B1D_9E37_0F5A; // stored password
    logic        clk_sys_in, rst_b_in, tck, tms, tdi, tdo, tdo_oe_b, cpu_hold, wdt_hold;
    logic        por, brown, unlock, sleep, window, start;
    logic [15:0] start_addr, old;
    logic [7:0]  cap;
    int          mismatches, check_count, por_n, brown_n, start_n, n;
    // ctrl rows: word in, old word out, {por count bit, wdt, hold}
    logic [15:0] rows [4][3] = '{'{16'h0001, 16'h0000, 16'h0001},
        '{16'h0005, 16'h0001, 16'h0003}, '{16'h0004, 16'h0005, 16'h0002},
        '{16'h0003, 16'h0004, 16'h0005}};
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    // pulse counters, so one-cycle pulses are never missed
    always @(posedge clk_sys_in) begin
        if (por === 1'b1) por_n <= por_n + 1;
        if (brown === 1'b1) brown_n <= brown_n + 1;
        if (start === 1'b1) start_n <= start_n + 1;
    end
    jpu_core #(.WINDOW_CYC(WIN), .PW_WORDS(4)) uut (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .password_in(PW), .reset_vector_in(16'h4400), .tdo_out(tdo),
        .tdo_oe_b_out(tdo_oe_b), .cpu_hold_out(cpu_hold), .wdt_hold_out(wdt_hold),
        .por_out(por), .brownout_reset_out(brown), .unlock_out(unlock),
        .deep_sleep_out(sleep), .window_out(window), .start_out(start),
        .start_addr_out(start_addr));
    jpu_host_model host (.tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // bounded wait for the next brownout pulse; n counts the cycles spent
    task automatic wait_brown();
        int b0;
        b0 = brown_n;
        n = 0;
        while (brown_n == b0 && n < WIN + 500) begin
            // look just after the edge, once the pulse counter has settled
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        if (brown_n == b0) begin
            mismatches++;
            complete_run();
        end
    endtask
    initial begin
        rst_b_in = 1'b0;
        {mismatches, check_count, por_n, brown_n, start_n} = '0;
        repeat (16) @(posedge clk_sys_in);
        #1 rst_b_in = 1'b1;
        check({15'h0, tdo_oe_b}, 16'h0001);
        $display("test reset done");
        host.tap_reset();
        host.ir_shift(jpu_pkg::INSTR_CTRL, cap);
        check({8'h0, cap}, {8'h0, jpu_pkg::PORT_ID});
        // ordinary control-register writes from the table
        for (int r = 0; r < 4; r++) begin
            host.dr_shift(rows[r][0], old);
            check(old, rows[r][1]);
            check({13'h0, por_n[0], wdt_hold, cpu_hold}, rows[r][2]);
        end
        $display("test control register done");
        // release with the reset marker, then with a plain address
        host.ir_shift(jpu_pkg::INSTR_RELEASE, cap);
        host.dr_shift(jpu_pkg::RESET_MARK, old);
        check(start_addr, 16'h4400);
        check({start_n[7:0], 7'h0, cpu_hold}, 16'h0100);
        host.dr_shift(16'h1234, old);
        check(start_addr, 16'h1234);
        $display("test release done");
        // wrong password: brownout, and the port falls back to bypass
        host.request_exchange();
        check({14'h0, window, sleep}, 16'h0003);
        host.send_password(PW ^ 64'h1, 4);
        check(brown_n[15:0], 16'h0001);
        check({12'h0, unlock, window, sleep, cpu_hold}, 16'h0000);
        host.walk(4'h0, 1);
        host.dr_shift(16'hA5A5, old);
        check(old, 16'h52D2);
        $display("test wrong password done");
        // no password at all: brownout when the window runs out
        host.request_exchange();
        wait_brown();
        check({15'h0, n > WIN - 40 && n <= WIN}, 16'h0001);
        $display("test window timeout done");
        // correct password unlocks and closes the window
        host.request_exchange();
        check({15'h0, sleep}, 16'h0001);
        host.send_password(PW, 4);
        check({14'h0, unlock, window}, 16'h0002);
        check(brown_n[15:0], 16'h0002);
        $display("test unlock done");
        complete_run();
    end
endmodule
`default_nettype wire
